/* File: logic/port_cfg_pkg.sv */
// Package: register map, field layout, reset values and carrier types for the port block
package port_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_DATA       = 10'h000;
  localparam logic [9:0]  IDX_IRQ_EN     = 10'h001;
  localparam logic [9:0]  IDX_DRIVE_LOW  = 10'h002;
  localparam logic [9:0]  IDX_DRIVE_HIGH = 10'h003;
  localparam logic [9:0]  IDX_IRQ_STATUS = 10'h004;
  localparam logic [9:0]  IDX_IRQ_MASK   = 10'h005;
  localparam logic [9:0]  IDX_GLOBAL_EN  = 10'h006;
  localparam logic [9:0]  IDX_CFG_STATE  = 10'h007;
  localparam logic [9:0]  IDX_CFG_ONE    = 10'h0DC;
  localparam logic [9:0]  IDX_CFG_TWO    = 10'h0DE;
  localparam int          ADDR_W         = 12;
  localparam int          IDX_LSB        = 2;

  // Reset values
  localparam logic [7:0]  RST_ZERO       = 8'h00;
  localparam logic [7:0]  RST_DRIVE_HIGH = 8'hFF;

  // Writable field masks
  localparam logic [7:0]  CFG_ONE_MASK   = 8'hBF;
  localparam logic [7:0]  CFG_TWO_MASK   = 8'h3B;
  localparam logic [7:0]  GLOBAL_EN_MASK = 8'h01;

  // io_config_one field positions
  localparam int          C1_BOOST       = 7;
  localparam int          C1_RANGE_HI    = 5;
  localparam int          C1_RANGE_LO    = 4;
  localparam int          C1_THRESHOLD   = 3;
  localparam int          C1_CLK_PIN     = 2;
  localparam int          C1_REG_EN      = 1;
  localparam int          C1_IRQ_MODE    = 0;

  // io_config_two field positions
  localparam int          C2_LEVEL_HI    = 5;
  localparam int          C2_LEVEL_LO    = 3;
  localparam int          C2_CLOCK_HI    = 1;
  localparam int          C2_CLOCK_LO    = 0;

  // Pin drive codes
  typedef enum logic [1:0] {
    DRIVE_PULL_UP   = 2'b00,
    DRIVE_STRONG    = 2'b01,
    DRIVE_HIGH_Z    = 2'b10,
    DRIVE_OPEN_LOW  = 2'b11
  } pin_drive_code_t;

  // Port 1 output level selections
  typedef enum logic [1:0] {
    LEVEL_3V0 = 2'b00,
    LEVEL_1V8 = 2'b01,
    LEVEL_2V5 = 2'b10
  } port1_level_t;

  // Regulator clock codes that are valid
  localparam logic [1:0]  REG_CLK_FAST   = 2'b10;
  localparam logic [1:0]  REG_CLK_SLOW   = 2'b01;

  // Pin pad controls, one bit per pin
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] in_en;
  } pin_pad_t;

  // Decoded global configuration
  typedef struct packed {
    logic         high_drive_boost;
    port1_level_t port1_level;
    logic         port1_reduced_threshold;
    logic         spi_clk_on_pin0;
    logic         spi_clk_on_pin3;
    logic         reg_enable;
    logic [2:0]   supply_step;
    logic [1:0]   reg_clock_sel;
    logic         reg_clock_valid;
  } io_cfg_t;

endpackage

/* File: logic/port_pin_drive_config.sv */
// Port drive mode, global I/O configuration and GPIO interrupt logic behind APB
//
// What this block does
// R1 - Pin code pairs high and low register bits
// R2 - Decode codes into pull-up, strong, high-Z, open-drain
// R3 - Reset sets all high drive bits
// R4 - High-Z pins read zero, no interrupt
// R5 - Software uses code 11 for shared digital
// R6 - Config one bit 7 boosts high drive
// R7 - Bits 5:4 pick port 1 level
// R8 - Bit 3 selects reduced input threshold
// R9 - Bit 2 maps serial clock pin
// R10 - Bit 1 enables port 1 regulator
// R11 - Bit 0 sets shared interrupt mode
// R12 - Config two bits 5:3 supply step
// R13 - Software matches regulator clock to system clock
// R14 - Mode clear: enabled low pin interrupts
// R15 - Mode set: pin differs from last read
// R16 - Unused bits zero; bad clock codes invalid
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

module port_pin_drive_config (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // APB slave
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [11:0]                  paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  output logic      [31:0]                  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  // Pins
  input  wire logic [7:0]                   pin_in_i,
  output port_cfg_pkg::pin_pad_t            pad_o,
  // Global I/O configuration
  output port_cfg_pkg::io_cfg_t             io_cfg_o,
  // Interrupts
  output logic                              gpio_irq_n_o,
  output logic                              irq_o
);

  // Registers
  logic [7:0]             port_data_q,     port_data_d;
  logic [7:0]             irq_enable_q,    irq_enable_d;
  logic [7:0]             drive_low_q,     drive_low_d;
  logic [7:0]             drive_high_q,    drive_high_d;
  logic [7:0]             irq_status_q,    irq_status_d;
  logic [7:0]             irq_mask_q,      irq_mask_d;
  logic [7:0]             global_en_q,     global_en_d;
  logic [7:0]             cfg_one_q,       cfg_one_d;
  logic [7:0]             cfg_two_q,       cfg_two_d;
  logic [7:0]             last_read_q,     last_read_d;
  logic [31:0]            prdata_q,        prdata_d;
  logic                   pready_q,        pready_d;
  logic                   pslverr_q,       pslverr_d;
  port_cfg_pkg::pin_pad_t pad_q,           pad_d;
  port_cfg_pkg::io_cfg_t  io_cfg_q,        io_cfg_d;
  logic                   gpio_irq_n_q,    gpio_irq_n_d;
  logic                   irq_q,           irq_d;

  // Combinational helpers
  logic [9:0]             idx;
  logic                   setup_phase;
  logic                   wr_done;
  logic                   rd_done;
  logic [7:0]             pin_read;
  logic [7:0]             pin_request;
  logic                   mapped;
  logic [7:0]             rd_byte;
  logic                   access_done;
  logic [1:0]             pin_code [8];

  // Pin code from the two drive registers
  function automatic port_cfg_pkg::pin_drive_code_t pin_drive_code(
    input logic [7:0] high_bits,
    input logic [7:0] low_bits,
    input int         pin
  );
    // R1 pair drive bits
    pin_drive_code = port_cfg_pkg::pin_drive_code_t'({high_bits[pin], low_bits[pin]});
  endfunction

  // Address decode shared by read and write
  function automatic logic is_mapped(input logic [9:0] a);
    unique case (a)
      port_cfg_pkg::IDX_DATA,
      port_cfg_pkg::IDX_IRQ_EN,
      port_cfg_pkg::IDX_DRIVE_LOW,
      port_cfg_pkg::IDX_DRIVE_HIGH,
      port_cfg_pkg::IDX_IRQ_STATUS,
      port_cfg_pkg::IDX_IRQ_MASK,
      port_cfg_pkg::IDX_GLOBAL_EN,
      port_cfg_pkg::IDX_CFG_STATE,
      port_cfg_pkg::IDX_CFG_ONE,
      port_cfg_pkg::IDX_CFG_TWO: is_mapped = 1'b1;
      default:                   is_mapped = 1'b0;
    endcase
  endfunction

  // Port 1 level from the two range bits
  function automatic port_cfg_pkg::port1_level_t port1_level_of(input logic [1:0] sel);
    unique case (sel)
      2'b10:   port1_level_of = port_cfg_pkg::LEVEL_1V8;
      2'b11:   port1_level_of = port_cfg_pkg::LEVEL_2V5;
      default: port1_level_of = port_cfg_pkg::LEVEL_3V0;
    endcase
  endfunction

  assign idx         = paddr_i[port_cfg_pkg::ADDR_W-1:port_cfg_pkg::IDX_LSB];
  assign setup_phase = psel_i && !penable_i;
  assign mapped      = is_mapped(idx);
  assign access_done = psel_i && penable_i && pready_q;
  assign wr_done     = access_done && pwrite_i && !pslverr_q;
  assign rd_done     = access_done && !pwrite_i && (idx == port_cfg_pkg::IDX_DATA);

  // Drive code of every pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // R1 code per pin
      pin_code[i] = pin_drive_code(drive_high_q, drive_low_q, i);
    end
  end

  // Input view per pin
  always_comb begin
    pin_read    = pin_in_i;
    for (int i = 0; i < 8; i++) begin
      // R4 high-Z reads zero
      if (pin_code[i] == port_cfg_pkg::DRIVE_HIGH_Z) begin
        pin_read[i] = 1'b0;
      end
    end
  end

  // Interrupt request per pin
  always_comb begin
    pin_request = '0;
    for (int i = 0; i < 8; i++) begin
      if (irq_enable_q[i] && pin_code[i] != port_cfg_pkg::DRIVE_HIGH_Z) begin
        if (cfg_one_q[port_cfg_pkg::C1_IRQ_MODE]) begin
          // R15 change from last read
          pin_request[i] = pin_read[i] != last_read_q[i];
        end else begin
          // R14 low level
          pin_request[i] = !pin_read[i];
        end
      end
    end
  end

  // Read mux
  always_comb begin
    rd_byte = port_cfg_pkg::RST_ZERO;
    unique case (idx)
      port_cfg_pkg::IDX_DATA:       rd_byte = pin_read;
      port_cfg_pkg::IDX_IRQ_EN:     rd_byte = irq_enable_q;
      port_cfg_pkg::IDX_DRIVE_LOW:  rd_byte = drive_low_q;
      port_cfg_pkg::IDX_DRIVE_HIGH: rd_byte = drive_high_q;
      port_cfg_pkg::IDX_IRQ_STATUS: rd_byte = irq_status_q;
      port_cfg_pkg::IDX_IRQ_MASK:   rd_byte = irq_mask_q;
      port_cfg_pkg::IDX_GLOBAL_EN:  rd_byte = global_en_q;
      port_cfg_pkg::IDX_CFG_STATE:  rd_byte = pin_request;
      port_cfg_pkg::IDX_CFG_ONE:    rd_byte = cfg_one_q;
      port_cfg_pkg::IDX_CFG_TWO:    rd_byte = cfg_two_q;
      default:                      rd_byte = port_cfg_pkg::RST_ZERO;
    endcase
  end

  // Bus answer: zero wait, data captured in the setup cycle
  always_comb begin
    pready_d  = setup_phase;
    pslverr_d = setup_phase && !mapped;
    prdata_d  = prdata_q;
    if (setup_phase) begin
      prdata_d = {24'h000000, rd_byte};
    end
  end

  // Register writes and read side effects
  always_comb begin
    port_data_d  = port_data_q;
    irq_enable_d = irq_enable_q;
    drive_low_d  = drive_low_q;
    drive_high_d = drive_high_q;
    irq_mask_d   = irq_mask_q;
    global_en_d  = global_en_q;
    cfg_one_d    = cfg_one_q;
    cfg_two_d    = cfg_two_q;
    last_read_d  = last_read_q;
    irq_status_d = irq_status_q;
    if (wr_done) begin
      unique case (idx)
        port_cfg_pkg::IDX_DATA:       port_data_d  = pwdata_i[7:0];
        port_cfg_pkg::IDX_IRQ_EN:     irq_enable_d = pwdata_i[7:0];
        port_cfg_pkg::IDX_DRIVE_LOW:  drive_low_d  = pwdata_i[7:0];
        port_cfg_pkg::IDX_DRIVE_HIGH: drive_high_d = pwdata_i[7:0];
        port_cfg_pkg::IDX_IRQ_STATUS: irq_status_d = irq_status_q & ~pwdata_i[7:0];
        port_cfg_pkg::IDX_IRQ_MASK:   irq_mask_d   = pwdata_i[7:0];
        // R16 unused bits dropped
        port_cfg_pkg::IDX_GLOBAL_EN:  global_en_d  = pwdata_i[7:0] & port_cfg_pkg::GLOBAL_EN_MASK;
        port_cfg_pkg::IDX_CFG_ONE:    cfg_one_d    = pwdata_i[7:0] & port_cfg_pkg::CFG_ONE_MASK;
        port_cfg_pkg::IDX_CFG_TWO:    cfg_two_d    = pwdata_i[7:0] & port_cfg_pkg::CFG_TWO_MASK;
        default:                      cfg_two_d    = cfg_two_q;
      endcase
    end
    // R15 capture on data read
    if (rd_done) begin
      last_read_d = pin_read;
    end
    // Set wins over clear
    irq_status_d = irq_status_d | pin_request;
  end

  // Pad drive per pin
  always_comb begin
    pad_d        = '0;
    pad_d.out    = port_data_q;
    for (int i = 0; i < 8; i++) begin
      // R2 drive decode
      unique case (pin_code[i])
        port_cfg_pkg::DRIVE_PULL_UP: begin
          pad_d.oe[i]      = !port_data_q[i];
          pad_d.pull_up[i] = port_data_q[i];
          pad_d.in_en[i]   = 1'b1;
        end
        port_cfg_pkg::DRIVE_STRONG: begin
          pad_d.oe[i]      = 1'b1;
          pad_d.in_en[i]   = 1'b1;
        end
        port_cfg_pkg::DRIVE_HIGH_Z: begin
          // R4 input buffer off
          pad_d.oe[i]      = 1'b0;
          pad_d.in_en[i]   = 1'b0;
        end
        port_cfg_pkg::DRIVE_OPEN_LOW: begin
          pad_d.oe[i]      = !port_data_q[i];
          pad_d.in_en[i]   = 1'b1;
        end
      endcase
    end
  end

  // Interrupt outputs
  always_comb begin
    // R11 pin enable and global gate
    gpio_irq_n_d = !(global_en_q[0] && (|pin_request));
    irq_d        = |(irq_status_q & irq_mask_q);
  end

  // Global configuration decode
  always_comb begin
    io_cfg_d = '0;
    // R6 drive boost
    io_cfg_d.high_drive_boost        = cfg_one_q[port_cfg_pkg::C1_BOOST];
    // R7 port 1 level
    io_cfg_d.port1_level = port1_level_of(
      cfg_one_q[port_cfg_pkg::C1_RANGE_HI:port_cfg_pkg::C1_RANGE_LO]);
    // R8 reduced threshold
    io_cfg_d.port1_reduced_threshold = cfg_one_q[port_cfg_pkg::C1_THRESHOLD];
    // R9 serial clock routing
    io_cfg_d.spi_clk_on_pin0         = cfg_one_q[port_cfg_pkg::C1_CLK_PIN];
    io_cfg_d.spi_clk_on_pin3         = !cfg_one_q[port_cfg_pkg::C1_CLK_PIN];
    // R10 regulator enable
    io_cfg_d.reg_enable              = cfg_one_q[port_cfg_pkg::C1_REG_EN];
    // R12 supply step
    io_cfg_d.supply_step = cfg_two_q[port_cfg_pkg::C2_LEVEL_HI:port_cfg_pkg::C2_LEVEL_LO];
    io_cfg_d.reg_clock_sel = cfg_two_q[port_cfg_pkg::C2_CLOCK_HI:port_cfg_pkg::C2_CLOCK_LO];
    // R16 only listed clock codes valid
    io_cfg_d.reg_clock_valid = (io_cfg_d.reg_clock_sel == port_cfg_pkg::REG_CLK_FAST) ||
                               (io_cfg_d.reg_clock_sel == port_cfg_pkg::REG_CLK_SLOW);
  end

  // Bus answer registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q     <= '0;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
    end else begin
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
    end
  end

  // Software visible registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_data_q  <= port_cfg_pkg::RST_ZERO;
      irq_enable_q <= port_cfg_pkg::RST_ZERO;
      drive_low_q  <= port_cfg_pkg::RST_ZERO;
      // R3 high-Z at reset
      drive_high_q <= port_cfg_pkg::RST_DRIVE_HIGH;
      irq_status_q <= port_cfg_pkg::RST_ZERO;
      irq_mask_q   <= port_cfg_pkg::RST_ZERO;
      global_en_q  <= port_cfg_pkg::RST_ZERO;
      cfg_one_q    <= port_cfg_pkg::RST_ZERO;
      cfg_two_q    <= port_cfg_pkg::RST_ZERO;
      last_read_q  <= port_cfg_pkg::RST_ZERO;
    end else begin
      port_data_q  <= port_data_d;
      irq_enable_q <= irq_enable_d;
      drive_low_q  <= drive_low_d;
      drive_high_q <= drive_high_d;
      irq_status_q <= irq_status_d;
      irq_mask_q   <= irq_mask_d;
      global_en_q  <= global_en_d;
      cfg_one_q    <= cfg_one_d;
      cfg_two_q    <= cfg_two_d;
      last_read_q  <= last_read_d;
    end
  end

  // Pad and interrupt output registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_q        <= '0;
      gpio_irq_n_q <= 1'b1;
      irq_q        <= 1'b0;
    end else begin
      pad_q        <= pad_d;
      gpio_irq_n_q <= gpio_irq_n_d;
      irq_q        <= irq_d;
    end
  end

  // Configuration output register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_cfg_q     <= '0;
    end else begin
      io_cfg_q     <= io_cfg_d;
    end
  end

  assign prdata_o     = prdata_q;
  assign pready_o     = pready_q;
  assign pslverr_o    = pslverr_q;
  assign pad_o        = pad_q;
  assign io_cfg_o     = io_cfg_q;
  assign gpio_irq_n_o = gpio_irq_n_q;
  assign irq_o        = irq_q;

endmodule

/* File: verif/port_pin_drive_config_properties.sv */
// Checker of APB timing, pad decode and configuration outputs
`timescale 1ns/1ps

module port_pin_drive_config_properties (
  // Clock, reset and APB
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [11:0]            paddr_i,
  input wire logic [31:0]            pwdata_i,
  input wire logic [31:0]            prdata_o,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  // Pins, configuration and interrupts
  input wire logic [7:0]             pin_in_i,
  input wire port_cfg_pkg::pin_pad_t pad_o,
  input wire port_cfg_pkg::io_cfg_t  io_cfg_o,
  input wire logic                   gpio_irq_n_o,
  input wire logic                   irq_o
);
  wire logic done    = psel_i && penable_i && pready_o;
  wire logic wr_one  = done && pwrite_i && paddr_i == {port_cfg_pkg::IDX_CFG_ONE, 2'b00};
  wire logic wr_two  = done && pwrite_i && paddr_i == {port_cfg_pkg::IDX_CFG_TWO, 2'b00};
  wire logic rd_data = done && !pwrite_i && paddr_i == {port_cfg_pkg::IDX_DATA, 2'b00};

  function automatic logic [1:0] lvl(input logic [1:0] r);
    return (r == 2'b10) ? 2'b01 : (r == 2'b11) ? 2'b10 : 2'b00;
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready_o |-> penable_i && $past(psel_i && !penable_i))
    else $error("ready outside access phase");
  a_refuse_zero: assert property (pready_o |->
    prdata_o[31:8] == 24'h0 && (!pslverr_o || prdata_o == 32'h0))
    else $error("read data not zero");
  a_cfg_one_apply: assert property (wr_one |-> ##2
    {io_cfg_o[12], io_cfg_o[9:6]} == {$past(pwdata_i[7], 2), $past(pwdata_i[3:2], 2),
    ~$past(pwdata_i[2], 2), $past(pwdata_i[1], 2)})
    else $error("config one outputs wrong");
  a_level_map: assert property (wr_one |-> ##2
    io_cfg_o.port1_level == lvl($past(pwdata_i[5:4], 2)))
    else $error("port level wrong");
  a_cfg_two_apply: assert property (wr_two |-> ##2
    io_cfg_o[5:1] == {$past(pwdata_i[5:3], 2), $past(pwdata_i[1:0], 2)})
    else $error("config two outputs wrong");
  a_clock_valid: assert property (io_cfg_o.reg_clock_valid == ^io_cfg_o.reg_clock_sel)
    else $error("clock valid wrong");
  a_pin_sel_excl: assert property ($past(rst_n_i) |->
    io_cfg_o.spi_clk_on_pin3 != io_cfg_o.spi_clk_on_pin0)
    else $error("clock pin select not exclusive");
  a_highz_quiet: assert property (((~pad_o.in_en) & (pad_o.oe | pad_o.pull_up)) == 8'h00)
    else $error("high impedance pin driven");
  a_pull_no_drive: assert property ((pad_o.pull_up & pad_o.oe) == 8'h00)
    else $error("pull up with drive");
  a_read_zero: assert property (rd_data |-> (prdata_o[7:0] & ~pad_o.in_en) == 8'h00)
    else $error("input off pin reads one");
endmodule

bind port_pin_drive_config port_pin_drive_config_properties chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_in_i(pin_in_i), .pad_o(pad_o),
  .io_cfg_o(io_cfg_o), .gpio_irq_n_o(gpio_irq_n_o), .irq_o(irq_o));

/* File: verif/port_pin_drive_config_bench.sv */
// Self-checking bench of the port drive and configuration block
`timescale 1ns/1ps

module port_pin_drive_config_bench;
  logic                   clk_i;
  logic                   rst_n_i;
  logic                   psel_i;
  logic                   penable_i;
  logic                   pwrite_i;
  logic [11:0]            paddr_i;
  logic [31:0]            pwdata_i;
  logic [31:0]            prdata_o;
  logic                   pready_o;
  logic                   pslverr_o;
  logic [7:0]             pin_in_i;
  port_cfg_pkg::pin_pad_t pad_o;
  port_cfg_pkg::io_cfg_t  io_cfg_o;
  logic                   gpio_irq_n_o;
  logic                   irq_o;
  int                     errors = 0;
  int                     n_compared = 0;
  logic [31:0]            rdata;
  logic                   rerr;
  logic [9:0]             idx_t [10];
  logic [7:0]             rst_t [10];
  logic [7:0]             ca [4];
  logic [7:0]             cb [4];

  port_pin_drive_config DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_in_i(pin_in_i), .pad_o(pad_o),
    .io_cfg_o(io_cfg_o), .gpio_irq_n_o(gpio_irq_n_o), .irq_o(irq_o));

  always #20 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {idx, 2'b00};
    pwdata_i  <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1);
    chk("access cycles", 32'h1, 32'(n));
    rdata = prdata_o;
    rerr  = pslverr_o;
  endtask

  task automatic rdc(input string nm, input logic [9:0] idx, input logic [31:0] e, input logic ee);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, rdata);
    chk("pslverr", 32'(ee), 32'(rerr));
  endtask

  task automatic settle;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  function automatic logic [12:0] cfg_exp(input logic [7:0] a, input logic [7:0] b);
    logic [1:0] lv;
    lv = (a[5:4] == 2'b10) ? 2'b01 : (a[5:4] == 2'b11) ? 2'b10 : 2'b00;
    return {a[7], lv, a[3], a[2], ~a[2], a[1], b[5:3], b[1:0], b[1] ^ b[0]};
  endfunction

  task automatic complete_run;
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    complete_run;
  end

  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pin_in_i = 8'hFF;
    idx_t = '{port_cfg_pkg::IDX_DATA, port_cfg_pkg::IDX_IRQ_EN, port_cfg_pkg::IDX_DRIVE_LOW,
      port_cfg_pkg::IDX_DRIVE_HIGH, port_cfg_pkg::IDX_IRQ_STATUS, port_cfg_pkg::IDX_IRQ_MASK,
      port_cfg_pkg::IDX_GLOBAL_EN, port_cfg_pkg::IDX_CFG_STATE, port_cfg_pkg::IDX_CFG_ONE,
      port_cfg_pkg::IDX_CFG_TWO};
    rst_t = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    ca = '{8'hFF, 8'h00, 8'h9A, 8'h65};
    cb = '{8'hFF, 8'h00, 8'h2A, 8'h11};
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      rdc("reset value", idx_t[i], 32'(rst_t[i]), 1'b0);
    end
    settle;
    chk("pad reset", 32'h0, 32'(pad_o));
    rdc("unmapped read", 10'h010, 32'h0, 1'b1);
    apb(1'b1, 10'h0DD, 32'hFF);
    chk("unmapped write", 32'h1, 32'(rerr));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, port_cfg_pkg::IDX_CFG_ONE, 32'(ca[i]));
      apb(1'b1, port_cfg_pkg::IDX_CFG_TWO, 32'(cb[i]));
      rdc("config one", port_cfg_pkg::IDX_CFG_ONE, 32'(ca[i] & 8'hBF), 1'b0);
      rdc("config two", port_cfg_pkg::IDX_CFG_TWO, 32'(cb[i] & 8'h3B), 1'b0);
      settle;
      chk("io cfg", 32'(cfg_exp(ca[i], cb[i])), 32'(io_cfg_o));
    end
    apb(1'b1, port_cfg_pkg::IDX_GLOBAL_EN, 32'hFF);
    rdc("global enable", port_cfg_pkg::IDX_GLOBAL_EN, 32'h01, 1'b0);
    apb(1'b1, port_cfg_pkg::IDX_DATA, 32'h0F);
    apb(1'b1, port_cfg_pkg::IDX_DRIVE_LOW, 32'hAA);
    apb(1'b1, port_cfg_pkg::IDX_DRIVE_HIGH, 32'hCC);
    rdc("drive low", port_cfg_pkg::IDX_DRIVE_LOW, 32'hAA, 1'b0);
    rdc("drive high", port_cfg_pkg::IDX_DRIVE_HIGH, 32'hCC, 1'b0);
    rdc("pin view", port_cfg_pkg::IDX_DATA, 32'hBB, 1'b0);
    settle;
    chk("pad", 32'h0FB201BB, 32'(pad_o));
    apb(1'b1, port_cfg_pkg::IDX_CFG_ONE, 32'h00);
    apb(1'b1, port_cfg_pkg::IDX_IRQ_EN, 32'hFF);
    pin_in_i <= 8'hFB;
    settle;
    chk("irq line", 32'h1, 32'(gpio_irq_n_o));
    pin_in_i <= 8'hFE;
    settle;
    chk("irq line", 32'h0, 32'(gpio_irq_n_o));
    chk("irq masked", 32'h0, 32'(irq_o));
    rdc("irq status", port_cfg_pkg::IDX_IRQ_STATUS, 32'h01, 1'b0);
    rdc("request state", port_cfg_pkg::IDX_CFG_STATE, 32'h01, 1'b0);
    apb(1'b1, port_cfg_pkg::IDX_IRQ_MASK, 32'h01);
    settle;
    chk("irq out", 32'h1, 32'(irq_o));
    apb(1'b1, port_cfg_pkg::IDX_IRQ_STATUS, 32'h01);
    rdc("status held", port_cfg_pkg::IDX_IRQ_STATUS, 32'h01, 1'b0);
    apb(1'b1, port_cfg_pkg::IDX_GLOBAL_EN, 32'h00);
    settle;
    chk("irq gated", 32'h1, 32'(gpio_irq_n_o));
    pin_in_i <= 8'hFF;
    settle;
    apb(1'b1, port_cfg_pkg::IDX_IRQ_STATUS, 32'h01);
    apb(1'b1, port_cfg_pkg::IDX_GLOBAL_EN, 32'h01);
    rdc("irq status", port_cfg_pkg::IDX_IRQ_STATUS, 32'h00, 1'b0);
    settle;
    chk("irq out", 32'h0, 32'(irq_o));
    apb(1'b1, port_cfg_pkg::IDX_CFG_ONE, 32'h01);
    rdc("pin view", port_cfg_pkg::IDX_DATA, 32'hBB, 1'b0);
    settle;
    chk("change idle", 32'h1, 32'(gpio_irq_n_o));
    pin_in_i <= 8'hF7;
    settle;
    chk("change low", 32'h0, 32'(gpio_irq_n_o));
    rdc("pin view", port_cfg_pkg::IDX_DATA, 32'hB3, 1'b0);
    settle;
    chk("change read", 32'h1, 32'(gpio_irq_n_o));
    pin_in_i <= 8'hFF;
    settle;
    chk("change high", 32'h0, 32'(gpio_irq_n_o));
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdc("drive high reset", port_cfg_pkg::IDX_DRIVE_HIGH, 32'hFF, 1'b0);
    settle;
    chk("pad after reset", 32'h0, 32'(pad_o));
    chk("io cfg reset", 32'(cfg_exp(8'h00, 8'h00)), 32'(io_cfg_o));
    chk("irq line reset", 32'h1, 32'(gpio_irq_n_o));
    complete_run;
  end
endmodule
